/* core/peak_detect_deglitch_defs.vh */
// Purpose: register map, field positions and reset values of the
//          extreme-record and comparator-filter block
// Assumes: 8-bit register space, 10-bit samples
// Notes:   definitions only, no logic
`ifndef PEAK_DETECT_DEGLITCH_DEFS_VH
`define PEAK_DETECT_DEGLITCH_DEFS_VH

// ----------------------------------------------------------------
// extreme record offsets
// ----------------------------------------------------------------
`define OFS_CURR_MIN_HI 8'h08
`define OFS_CURR_MIN_LO 8'h09
`define OFS_CURR_MAX_HI 8'h0a
`define OFS_CURR_MAX_LO 8'h0b
`define OFS_VOLT_MIN_HI 8'h0c
`define OFS_VOLT_MIN_LO 8'h0d
`define OFS_VOLT_MAX_HI 8'h0e
`define OFS_VOLT_PEAK_LOW_BITS 8'h0f

// ----------------------------------------------------------------
// control register offsets
// ----------------------------------------------------------------
`define OFS_CURR_WARN_FILTER_ENABLE 8'h3c
`define OFS_UNDERVOLT_FILTER_ENABLE 8'h3d
`define OFS_OVERVOLT_FILTER_ENABLE 8'h3e
`define OFS_EXTREME_RECORD_CLEAR 8'h41
`define OFS_EXTREME_RECORD_FREEZE 8'h42

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_CURRENT 0
`define BIT_VOLTAGE 1
`define BIT_LEVEL_A 0
`define BIT_LEVEL_B 1
`define BIT_CURR_WARN_FILTER 0

// comparator index on the raw and filtered vectors
`define CMP_CURR_WARN 0
`define CMP_UV_A 1
`define CMP_UV_B 2
`define CMP_OV_A 3
`define CMP_OV_B 4

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_CONTROL 8'h00
`define RST_MIN_RECORD 10'h3ff
`define RST_MAX_RECORD 10'h000
`define READ_UNMAPPED 8'h00
`define FILTER_COUNT 2

`endif

/* core/extreme_tracker.v */
// Purpose: min and max record of one 10-bit sample stream
// Assumes: sample_valid_i is a one-cycle strobe per conversion
// Notes:   freeze outranks clear; both outrank sampling
`timescale 1ns/1ps
`include "peak_detect_deglitch_defs.vh"

module extreme_tracker #(
	parameter W = 10
) (
	input wire sys_clk_i,
	input wire rst_b_i,
	input wire sample_valid_i,
	input wire [W-1:0] sample_i,
	input wire clear_i,
	input wire freeze_i,
	output reg [W-1:0] min_rec_o,
	output reg [W-1:0] max_rec_o
);

	// ------------------------------------------------------------
	// record update
	// ------------------------------------------------------------
	// a clear under freeze is ignored so held records survive
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			min_rec_o <= `RST_MIN_RECORD;
			max_rec_o <= `RST_MAX_RECORD;
		end else if (freeze_i) begin
			min_rec_o <= min_rec_o;
			max_rec_o <= max_rec_o;
		end else if (clear_i) begin
			min_rec_o <= `RST_MIN_RECORD;
			max_rec_o <= `RST_MAX_RECORD;
		end else if (sample_valid_i) begin
			if (sample_i > max_rec_o)
				max_rec_o <= sample_i;
			if (sample_i < min_rec_o)
				min_rec_o <= sample_i;
		end
	end

endmodule

/* core/compare_filter.v */
// Purpose: optional two-sample filter for one limit comparator
// Assumes: raw result is valid on the cycle of sample_valid_i
// Notes:   output is a level that changes only on sample strobes
`timescale 1ns/1ps
`include "peak_detect_deglitch_defs.vh"

module compare_filter #(
	parameter COUNT = `FILTER_COUNT
) (
	input wire sys_clk_i,
	input wire rst_b_i,
	input wire sample_valid_i,
	input wire raw_i,
	input wire enable_i,
	output reg filtered_o
);

	reg [3:0] run;
	wire [3:0] next_run;

	// consecutive positives, saturating at the filter count
	assign next_run = !raw_i ? 4'h0 :
		(run >= COUNT[3:0]) ? COUNT[3:0] : run + 4'h1;

	// ------------------------------------------------------------
	// run counter and filtered flag
	// ------------------------------------------------------------
	// a negative compare restarts the run, so glitches never add up
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			run <= 4'h0;
			filtered_o <= 1'b0;
		end else if (sample_valid_i) begin
			run <= next_run;
			if (enable_i)
				filtered_o <= (next_run >= COUNT[3:0]);
			else
				filtered_o <= raw_i;
		end
	end

endmodule

/* core/peak_detect_deglitch.v */
// Purpose: extreme records of voltage and current, with clear and
//          freeze controls, and filter enables for five comparators
// Assumes: register port sits behind the serial slave interface;
//          samples and raw compares are synchronous to sys_clk_i
// Notes:   read data is registered, one cycle after the read strobe;
//          a record's two bytes are not captured together: freeze first
//
// Contract
// - clear bit one clears that signal's records
// - clear loads minimum all ones, maximum zero
// - clear held at one keeps records reset
// - freeze bit stops tracking; zero resumes it
// - clear ignored while records frozen
// - clear register: voltage bit 1, current 0
// - filter needs two consecutive positive compares
// - enable one filters, zero passes single compares
// - current warning filter enable at bit 0
// - undervoltage filter enables at bits 1,0
// - overvoltage filter enables at bits 1,0
// - voltage maximum low bits readable, reset zero
// - larger sample raises max, smaller lowers min
// - records split into bits 9:2 and 1:0
`timescale 1ns/1ps
`include "peak_detect_deglitch_defs.vh"

module peak_detect_deglitch #(
	parameter SAMPLE_W = 10,
	parameter NUM_CMP = 5
) (
	input wire sys_clk_i,
	input wire rst_b_i,
	input wire [7:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	output reg reg_rvalid_o,
	input wire volt_valid_i,
	input wire [SAMPLE_W-1:0] volt_sample_i,
	input wire curr_valid_i,
	input wire [SAMPLE_W-1:0] curr_sample_i,
	input wire [NUM_CMP-1:0] compare_raw_i,
	output wire [NUM_CMP-1:0] compare_filtered_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// upper eight bits of a record, as a read byte
	function [7:0] hi_byte;
		input [SAMPLE_W-1:0] rec;
		begin
			hi_byte = rec[SAMPLE_W-1:SAMPLE_W-8];
		end
	endfunction

	// two low bits of a record in bits 1:0, rest zero
	function [7:0] lo_byte;
		input [SAMPLE_W-1:0] rec;
		begin
			lo_byte = {6'h00, rec[1:0]};
		end
	endfunction

	// true on a write to the given offset
	function wr_hit;
		input [7:0] addr;
		input wr;
		input [7:0] ofs;
		begin
			wr_hit = wr && (addr == ofs);
		end
	endfunction

	// two control bits in bits 1:0, reserved bits read zero
	function [7:0] bit_pair;
		input hi;
		input lo;
		begin
			bit_pair = {6'h00, hi, lo};
		end
	endfunction

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire wr_curr_filter;
	wire wr_uv_filter;
	wire wr_ov_filter;
	wire wr_clear;
	wire wr_freeze;

	// record offsets never match, so writes to them are dropped
	assign wr_curr_filter = wr_hit(reg_addr_i, reg_wr_i, `OFS_CURR_WARN_FILTER_ENABLE);
	assign wr_uv_filter = wr_hit(reg_addr_i, reg_wr_i, `OFS_UNDERVOLT_FILTER_ENABLE);
	assign wr_ov_filter = wr_hit(reg_addr_i, reg_wr_i, `OFS_OVERVOLT_FILTER_ENABLE);
	assign wr_clear = wr_hit(reg_addr_i, reg_wr_i, `OFS_EXTREME_RECORD_CLEAR);
	assign wr_freeze = wr_hit(reg_addr_i, reg_wr_i, `OFS_EXTREME_RECORD_FREEZE);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	reg curr_warn_filter_enable;
	reg undervolt_level_a_filter;
	reg undervolt_level_b_filter;
	reg overvolt_level_a_filter;
	reg overvolt_level_b_filter;
	reg voltage_extreme_clear;
	reg current_extreme_clear;
	reg voltage_extreme_freeze;
	reg current_extreme_freeze;
	reg next_curr_warn_filter_enable;
	reg next_undervolt_level_a_filter;
	reg next_undervolt_level_b_filter;
	reg next_overvolt_level_a_filter;
	reg next_overvolt_level_b_filter;
	reg next_voltage_extreme_clear;
	reg next_current_extreme_clear;
	reg next_voltage_extreme_freeze;
	reg next_current_extreme_freeze;

	// unaddressed registers keep their value; unused bits are dropped
	always @* begin
		next_curr_warn_filter_enable = curr_warn_filter_enable;
		next_undervolt_level_a_filter = undervolt_level_a_filter;
		next_undervolt_level_b_filter = undervolt_level_b_filter;
		next_overvolt_level_a_filter = overvolt_level_a_filter;
		next_overvolt_level_b_filter = overvolt_level_b_filter;
		next_voltage_extreme_clear = voltage_extreme_clear;
		next_current_extreme_clear = current_extreme_clear;
		next_voltage_extreme_freeze = voltage_extreme_freeze;
		next_current_extreme_freeze = current_extreme_freeze;
		if (wr_curr_filter)
			next_curr_warn_filter_enable = reg_wdata_i[`BIT_CURR_WARN_FILTER];
		if (wr_uv_filter) begin
			next_undervolt_level_a_filter = reg_wdata_i[`BIT_LEVEL_A];
			next_undervolt_level_b_filter = reg_wdata_i[`BIT_LEVEL_B];
		end
		if (wr_ov_filter) begin
			next_overvolt_level_a_filter = reg_wdata_i[`BIT_LEVEL_A];
			next_overvolt_level_b_filter = reg_wdata_i[`BIT_LEVEL_B];
		end
		// clear bits stay set until software writes zero
		if (wr_clear) begin
			next_voltage_extreme_clear = reg_wdata_i[`BIT_VOLTAGE];
			next_current_extreme_clear = reg_wdata_i[`BIT_CURRENT];
		end
		if (wr_freeze) begin
			next_voltage_extreme_freeze = reg_wdata_i[`BIT_VOLTAGE];
			next_current_extreme_freeze = reg_wdata_i[`BIT_CURRENT];
		end
	end

	// writes land on the next edge, so a read in the same cycle sees the old value
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			curr_warn_filter_enable <= 1'b0;
			undervolt_level_a_filter <= 1'b0;
			undervolt_level_b_filter <= 1'b0;
			overvolt_level_a_filter <= 1'b0;
			overvolt_level_b_filter <= 1'b0;
			voltage_extreme_clear <= 1'b0;
			current_extreme_clear <= 1'b0;
			voltage_extreme_freeze <= 1'b0;
			current_extreme_freeze <= 1'b0;
		end else begin
			curr_warn_filter_enable <= next_curr_warn_filter_enable;
			undervolt_level_a_filter <= next_undervolt_level_a_filter;
			undervolt_level_b_filter <= next_undervolt_level_b_filter;
			overvolt_level_a_filter <= next_overvolt_level_a_filter;
			overvolt_level_b_filter <= next_overvolt_level_b_filter;
			voltage_extreme_clear <= next_voltage_extreme_clear;
			current_extreme_clear <= next_current_extreme_clear;
			voltage_extreme_freeze <= next_voltage_extreme_freeze;
			current_extreme_freeze <= next_current_extreme_freeze;
		end
	end

	// ------------------------------------------------------------
	// extreme records
	// ------------------------------------------------------------
	wire [SAMPLE_W-1:0] volt_min;
	wire [SAMPLE_W-1:0] volt_max;
	wire [SAMPLE_W-1:0] curr_min;
	wire [SAMPLE_W-1:0] curr_max;

	// a clear left at one keeps the records at their reset values
	// one tracker per signal; freeze wins over a pending clear
	extreme_tracker #(
		.W(SAMPLE_W)
	) u_volt_track (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.sample_valid_i(volt_valid_i),
		.sample_i(volt_sample_i),
		.clear_i(voltage_extreme_clear),
		.freeze_i(voltage_extreme_freeze),
		.min_rec_o(volt_min),
		.max_rec_o(volt_max)
	);

	// current records obey the same clear and freeze rules
	extreme_tracker #(
		.W(SAMPLE_W)
	) u_curr_track (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.sample_valid_i(curr_valid_i),
		.sample_i(curr_sample_i),
		.clear_i(current_extreme_clear),
		.freeze_i(current_extreme_freeze),
		.min_rec_o(curr_min),
		.max_rec_o(curr_max)
	);

	// ------------------------------------------------------------
	// comparator filters
	// ------------------------------------------------------------
	wire [NUM_CMP-1:0] filter_enable;
	wire [NUM_CMP-1:0] filter_strobe;

	// enables gathered in comparator order
	assign filter_enable[`CMP_CURR_WARN] = curr_warn_filter_enable;
	assign filter_enable[`CMP_UV_A] = undervolt_level_a_filter;
	assign filter_enable[`CMP_UV_B] = undervolt_level_b_filter;
	assign filter_enable[`CMP_OV_A] = overvolt_level_a_filter;
	assign filter_enable[`CMP_OV_B] = overvolt_level_b_filter;

	// the current comparator counts current samples, the rest voltage
	assign filter_strobe[`CMP_CURR_WARN] = curr_valid_i;
	assign filter_strobe[`CMP_UV_A] = volt_valid_i;
	assign filter_strobe[`CMP_UV_B] = volt_valid_i;
	assign filter_strobe[`CMP_OV_A] = volt_valid_i;
	assign filter_strobe[`CMP_OV_B] = volt_valid_i;

	// one filter per comparator, each counting on its own strobe
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CMP; gi = gi + 1) begin : g_filter
			compare_filter #(
				.COUNT(`FILTER_COUNT)
			) u_filter (
				.sys_clk_i(sys_clk_i),
				.rst_b_i(rst_b_i),
				.sample_valid_i(filter_strobe[gi]),
				.raw_i(compare_raw_i[gi]),
				.enable_i(filter_enable[gi]),
				.filtered_o(compare_filtered_o[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	reg [7:0] next_rdata;

	// reserved bits and unmapped offsets read as zero
	always @* begin
		next_rdata = `READ_UNMAPPED;
		case (reg_addr_i)
			`OFS_CURR_MIN_HI: next_rdata = hi_byte(curr_min);
			`OFS_CURR_MIN_LO: next_rdata = lo_byte(curr_min);
			`OFS_CURR_MAX_HI: next_rdata = hi_byte(curr_max);
			`OFS_CURR_MAX_LO: next_rdata = lo_byte(curr_max);
			`OFS_VOLT_MIN_HI: next_rdata = hi_byte(volt_min);
			`OFS_VOLT_MIN_LO: next_rdata = lo_byte(volt_min);
			`OFS_VOLT_MAX_HI: next_rdata = hi_byte(volt_max);
			`OFS_VOLT_PEAK_LOW_BITS: next_rdata = lo_byte(volt_max);
			`OFS_CURR_WARN_FILTER_ENABLE:
				next_rdata = {7'h00, curr_warn_filter_enable};
			`OFS_UNDERVOLT_FILTER_ENABLE:
				next_rdata = bit_pair(undervolt_level_b_filter,
					undervolt_level_a_filter);
			`OFS_OVERVOLT_FILTER_ENABLE:
				next_rdata = bit_pair(overvolt_level_b_filter,
					overvolt_level_a_filter);
			`OFS_EXTREME_RECORD_CLEAR:
				next_rdata = bit_pair(voltage_extreme_clear,
					current_extreme_clear);
			`OFS_EXTREME_RECORD_FREEZE:
				next_rdata = bit_pair(voltage_extreme_freeze,
					current_extreme_freeze);
			default: next_rdata = `READ_UNMAPPED;
		endcase
	end

	// read data latched on the strobe, held until the next read
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= `RST_CONTROL;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= next_rdata;
		end
	end

endmodule

/* testbench/peak_detect_deglitch_checker.sv */
// Purpose: port-level checks of the extreme-record and filter block
// Assumes: one clock, synchronous active-low reset
// Notes: read data checked one cycle after the read strobe
`timescale 1ns/1ps
module peak_detect_deglitch_checker #(
	parameter SAMPLE_W = 10,
	parameter NUM_CMP = 5
) (
	input wire sys_clk_i,
	input wire rst_b_i,
	input wire [7:0] reg_addr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire reg_rvalid_o,
	input wire volt_valid_i,
	input wire curr_valid_i,
	input wire [NUM_CMP-1:0] compare_raw_i,
	input wire [NUM_CMP-1:0] compare_filtered_o
);
	// ----------------------------------------------------------------
	// register view and filter outputs
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// unused bits must read zero, else software masks break
	chk_clear_upper: assert property (reg_rd_i && reg_addr_i == 8'h41 |=>
		reg_rvalid_o && reg_rdata_o[7:2] == 6'h00) else $error("clear reg upper bits");
	chk_freeze_upper: assert property (reg_rd_i && reg_addr_i == 8'h42 |=>
		reg_rdata_o[7:2] == 6'h00) else $error("freeze reg upper bits");
	chk_curr_filter_width: assert property (reg_rd_i && reg_addr_i == 8'h3c |=>
		reg_rdata_o[7:1] == 7'h00) else $error("current filter reg upper bits");
	chk_volt_filter_width: assert property ((reg_rd_i &&
		(reg_addr_i == 8'h3d || reg_addr_i == 8'h3e))
		|=> reg_rdata_o[7:2] == 6'h00) else $error("voltage filter reg upper bits");
	chk_peak_low_bits: assert property (reg_rd_i && reg_addr_i == 8'h0f |=>
		reg_rdata_o[7:2] == 6'h00) else $error("low-bits record upper bits");
	// filtered levels move only on their own strobe
	chk_curr_filter_hold: assert property (!curr_valid_i |=>
		$stable(compare_filtered_o[0])) else $error("current filter moved");
	chk_volt_filter_hold: assert property (!volt_valid_i |=>
		$stable(compare_filtered_o[4:1])) else $error("voltage filter moved");
	chk_negative_clears: assert property (curr_valid_i && !compare_raw_i[0] |=>
		!compare_filtered_o[0]) else $error("negative compare kept output");
	chk_volt_negative: assert property (volt_valid_i |=>
		(compare_filtered_o[4:1] & ~$past(compare_raw_i[4:1])) == 4'h0)
		else $error("voltage output without positive compare");
	chk_rise_needs_raw: assert property ($rose(compare_filtered_o[0]) |->
		$past(curr_valid_i && compare_raw_i[0])) else $error("rise without compare");
	cover property (volt_valid_i && compare_raw_i[1] ##4 volt_valid_i && compare_raw_i[1]);
	cover property (reg_rd_i && reg_addr_i == 8'h41);
	cover property (curr_valid_i ##1 compare_filtered_o[0]);
endmodule

/* testbench/adc_stream_model.sv */
// Purpose: conversion strobes, samples and raw compares
// Assumes: driven just after the rising edge
// Notes: lines show inverse values between strobes
`timescale 1ns/1ps
module adc_stream_model (
	input wire logic clk_i,
	output logic volt_valid_o,
	output logic [9:0] volt_sample_o,
	output logic curr_valid_o,
	output logic [9:0] curr_sample_o,
	output logic [4:0] raw_o
);
	// ----------------------------------------------------------------
	// one conversion
	// ----------------------------------------------------------------
	initial begin
		volt_valid_o = 1'b0;
		curr_valid_o = 1'b0;
		volt_sample_o = 10'h000;
		curr_sample_o = 10'h000;
		raw_o = 5'h00;
	end
	// stale data is scrambled so it can never pass for a sample
	task automatic send(input bit is_volt, input logic [9:0] s, input logic [4:0] r);
		@(posedge clk_i);
		volt_valid_o <= is_volt;
		curr_valid_o <= !is_volt;
		volt_sample_o <= s;
		curr_sample_o <= s;
		raw_o <= r;
		@(posedge clk_i);
		volt_valid_o <= 1'b0;
		curr_valid_o <= 1'b0;
		volt_sample_o <= ~s;
		curr_sample_o <= ~s;
		raw_o <= ~r;
	endtask
endmodule

/* testbench/tb.sv */
// Purpose: register and stream tests of the extreme-record block
// Assumes: strobe register port, 40 MHz clock
// Notes: expected values from the register map only
`timescale 1ns/1ps
module tb;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	wire [7:0] reg_rdata_o;
	wire reg_rvalid_o, vv, cv;
	wire [9:0] vs, cs;
	wire [4:0] raw, filt;
	int num_errors = 0;
	int num_checks = 0;
	logic [7:0] rofs [0:13] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
		8'h3c, 8'h3d, 8'h3e, 8'h41, 8'h42, 8'h20};
	logic [7:0] rexp [0:13] = '{8'hff, 8'h03, 8'h00, 8'h00, 8'hff, 8'h03, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] texp [0:7] = '{8'h7f, 8'h02, 8'h81, 8'h01, 8'h7f, 8'h02, 8'h81, 8'h01};
	logic [9:0] smp [0:2] = '{10'h205, 10'h1fe, 10'h203};
	logic [4:0] fraw [0:3] = '{5'h1f, 5'h1f, 5'h00, 5'h1f};
	logic [4:0] fexp [0:3] = '{5'h00, 5'h1f, 5'h00, 5'h00};
	// ----------------------------------------------------------------
	// clock, instances, bus tasks
	// ----------------------------------------------------------------
	always #12.5 sys_clk_i = ~sys_clk_i;
	peak_detect_deglitch peak_detect_deglitch_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.volt_valid_i(vv), .volt_sample_i(vs), .curr_valid_i(cv), .curr_sample_i(cs),
		.compare_raw_i(raw), .compare_filtered_o(filt));
	adc_stream_model adc_stream_model_inst (.clk_i(sys_clk_i), .volt_valid_o(vv),
		.volt_sample_o(vs), .curr_valid_o(cv), .curr_sample_o(cs), .raw_o(raw));
	task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic chk5(input logic [4:0] exp, input logic [4:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// bounded wait so a missing answer cannot hang the run
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		int n = 0;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		while (reg_rvalid_o !== 1'b1 && n < 4) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		chk8(8'h01, {7'h00, reg_rvalid_o});
		chk8(exp, reg_rdata_o);
	endtask
	task automatic step(input logic [4:0] r, input logic [4:0] exp);
		adc_stream_model_inst.send(1'b1, 10'h100, r);
		adc_stream_model_inst.send(1'b0, 10'h100, r);
		#1;
		chk5(exp, filt);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#(25 * 4000);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		foreach (rofs[i]) rd_chk(rofs[i], rexp[i]);
		$display("reset values done");
		foreach (smp[i]) begin
			adc_stream_model_inst.send(1'b1, smp[i], 5'h00);
			adc_stream_model_inst.send(1'b0, smp[i], 5'h00);
		end
		foreach (texp[i]) rd_chk(rofs[i], texp[i]);
		$display("tracking done");
		wr(8'h42, 8'h02);
		adc_stream_model_inst.send(1'b1, 10'h3ff, 5'h00);
		adc_stream_model_inst.send(1'b1, 10'h000, 5'h00);
		wr(8'h41, 8'hfe);
		rd_chk(8'h41, 8'h02);
		rd_chk(8'h0e, 8'h81);
		rd_chk(8'h0c, 8'h7f);
		wr(8'h42, 8'h00);
		rd_chk(8'h0c, 8'hff);
		adc_stream_model_inst.send(1'b1, 10'h100, 5'h00);
		rd_chk(8'h0e, 8'h00);
		rd_chk(8'h0a, 8'h81);
		wr(8'h41, 8'h00);
		adc_stream_model_inst.send(1'b1, 10'h155, 5'h00);
		wr(8'h0f, 8'hff);
		rd_chk(8'h0e, 8'h55);
		rd_chk(8'h0f, 8'h01);
		rd_chk(8'h0d, 8'h01);
		wr(8'h42, 8'h01);
		adc_stream_model_inst.send(1'b0, 10'h3ff, 5'h00);
		rd_chk(8'h0a, 8'h81);
		$display("clear and freeze done");
		wr(8'h3c, 8'hff);
		wr(8'h3d, 8'hff);
		wr(8'h3e, 8'hff);
		rd_chk(8'h3c, 8'h01);
		rd_chk(8'h3d, 8'h03);
		rd_chk(8'h3e, 8'h03);
		foreach (fraw[i]) step(fraw[i], fexp[i]);
		wr(8'h3c, 8'h00);
		wr(8'h3d, 8'h01);
		wr(8'h3e, 8'h02);
		step(5'h00, 5'h00);
		step(5'h1f, 5'h0d);
		$display("filters done");
		tally_and_finish();
	end
endmodule
bind peak_detect_deglitch peak_detect_deglitch_checker #(.SAMPLE_W(SAMPLE_W),
	.NUM_CMP(NUM_CMP)) peak_detect_deglitch_checker_inst (.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .volt_valid_i(volt_valid_i),
	.curr_valid_i(curr_valid_i), .compare_raw_i(compare_raw_i),
	.compare_filtered_o(compare_filtered_o));
